// [rtl/fault_group_unit.sv]
// fault group unit: category decode, fault output masks, malfunction
// snapshots and thermistor trip reaction behind a Wishbone slave.
// assumes fault strobe, code and live values come from logic on I_CLK.
//
// Overview of operation
// RULE_01 - low-voltage 11-14 and phase loss 15 set voltage
// RULE_02 - code 62 sets voltage bit
// RULE_03 - codes 21, 27, 87 set overload
// RULE_04 - codes 128, 129, 134, 135 set overload
// RULE_05 - codes 28, 79, 80, 82 set current
// RULE_06 - codes 31, 33-37 set system bit
// RULE_07 - codes 40, 52, 127, 142 set system
// RULE_08 - safety codes 72, 76-78 set system
// RULE_09 - codes 45, 48, 89 set feedback
// RULE_10 - codes 49-51, 61, 63 set external
// RULE_11 - codes 58, 101-107 set communication; the decode leaves out code 103
// RULE_12 - codes 121, 123, 124, 126 set communication
// RULE_13 - thermistor reaction chosen by 2-bit select
// RULE_14 - trip level 0-100 percent, reset 50
// RULE_15 - detect only with channel function six
// RULE_16 - capture frequency command on malfunction
// RULE_17 - capture output frequency on malfunction
// RULE_18 - capture output voltage on malfunction
// RULE_19 - records keep latest, ignore software writes
// RULE_20 - masks drive terminals on category overlap
// RULE_21 - unassigned codes give zero category vector
// RULE_22 - all records captured with fault code
`timescale 1ns/100ps

module fault_group_unit #(
  parameter logic [15:0] AIN_FULL = 16'hffff // analog full scale
) (
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire logic I_CE,
  // classic Wishbone slave
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [7:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  // malfunction event and live values
  input wire logic I_FAULT_VALID,
  input wire logic [7:0] I_FAULT_CODE,
  input wire fault_pkg::snap_t I_LIVE,
  input wire logic [fault_pkg::NUM_AIN-1:0][15:0] I_AIN_LEVEL,
  // results
  output logic [fault_pkg::GRP_W-1:0] O_FAULT_GROUP,
  output logic [fault_pkg::NUM_MASK-1:0] O_FAULT_TERM,
  output fault_pkg::therm_out_t O_THERM
);
  import fault_pkg::*;

  // ==========================================================
  // state
  logic [1:0] therm_action; // reaction select
  logic [9:0] therm_level; // tenths of a percent
  logic [15:0] mask [NUM_MASK]; // terminal masks
  logic [7:0] ain_func [NUM_AIN]; // per-channel function code
  snap_t snap; // last malfunction record
  logic [7:0] last_code; // latched fault code
  logic [31:0] rd_data; // read mux result
  logic wr_en; // write commits this edge
  logic therm_en; // some channel is a thermistor
  logic [15:0] therm_sample; // chosen channel sample
  logic therm_over; // sample at or above level

  // scaled compare, product widths kept explicit
  function automatic logic above_level(input logic [15:0] sample,
      input logic [9:0] level);
    logic [25:0] lhs;
    logic [25:0] rhs;
    lhs = 26'(sample) * 26'(THERM_LEVEL_MAX);
    rhs = 26'(level) * 26'(AIN_FULL);
    return lhs >= rhs;
  endfunction

  // ==========================================================
  // bus: one-cycle answer, write lands on the acked edge
  assign wr_en = I_WB_CYC && I_WB_STB && I_WB_WE && O_WB_ACK;

  // ack rises one edge after the request, drops the next
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_WB_ACK <= 1'b0;
    end else if (I_CE) begin
      O_WB_ACK <= I_WB_CYC && I_WB_STB && !O_WB_ACK;
    end
  end

  // read mux; unmapped offsets read zero and still ack
  always_comb begin
    rd_data = '0;
    case (I_WB_ADR)
      OFS_THERM_ACTION: rd_data[1:0] = therm_action;
      OFS_THERM_LEVEL: rd_data[9:0] = therm_level;
      OFS_SNAP_FCMD: rd_data[15:0] = snap.freq_cmd;
      OFS_SNAP_FOUT: rd_data[15:0] = snap.out_freq;
      OFS_SNAP_VOUT: rd_data[15:0] = snap.out_volt;
      OFS_STATUS: rd_data[15:0] = {therm_over, O_FAULT_GROUP, last_code};
      default: begin
        for (int m = 0; m < NUM_MASK; m++) begin
          if (I_WB_ADR == 8'(OFS_MASK0 + 8'(m) * OFS_STRIDE)) begin
            rd_data[15:0] = mask[m];
          end
        end
        for (int c = 0; c < NUM_AIN; c++) begin
          if (I_WB_ADR == 8'(OFS_AIN_FUNC0 + 8'(c) * OFS_STRIDE)) begin
            rd_data[7:0] = ain_func[c];
          end
        end
      end
    endcase
  end

  // read data registered with the ack
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_WB_DAT <= '0;
    end else if (I_CE && I_WB_CYC && I_WB_STB && !O_WB_ACK) begin
      O_WB_DAT <= rd_data;
    end
  end

  // ==========================================================
  // control registers
  // RULE_13 reaction select register
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      therm_action <= THERM_ACTION_RST;
    end else if (I_CE && wr_en && I_WB_ADR == OFS_THERM_ACTION &&
                 I_WB_SEL[0]) begin
      therm_action <= I_WB_DAT[1:0];
    end
  end

  // RULE_14 trip level, clamped to full scale
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      therm_level <= THERM_LEVEL_RST;
    end else if (I_CE && wr_en && I_WB_ADR == OFS_THERM_LEVEL &&
                 I_WB_SEL[1:0] == 2'h3) begin
      if (I_WB_DAT[15:0] > 16'(THERM_LEVEL_MAX)) begin
        therm_level <= THERM_LEVEL_MAX;
      end else begin
        therm_level <= I_WB_DAT[9:0];
      end
    end
  end

  // masks and channel functions, byte lanes honoured
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      for (int m = 0; m < NUM_MASK; m++) mask[m] <= MASK_RST;
      for (int c = 0; c < NUM_AIN; c++) ain_func[c] <= AIN_FUNC_RST;
    end else if (I_CE && wr_en) begin
      for (int m = 0; m < NUM_MASK; m++) begin
        if (I_WB_ADR == 8'(OFS_MASK0 + 8'(m) * OFS_STRIDE)) begin
          if (I_WB_SEL[0]) mask[m][7:0] <= I_WB_DAT[7:0];
          if (I_WB_SEL[1]) mask[m][15:8] <= I_WB_DAT[15:8];
        end
      end
      for (int c = 0; c < NUM_AIN; c++) begin
        if (I_WB_ADR == 8'(OFS_AIN_FUNC0 + 8'(c) * OFS_STRIDE) &&
            I_WB_SEL[0]) begin
          ain_func[c] <= I_WB_DAT[7:0];
        end
      end
    end
  end

  // ==========================================================
  // malfunction capture
  // RULE_16 RULE_17 RULE_18 RULE_22 one-edge capture
  // snapshot writes from the bus are never decoded here,
  // so the records stay read-only
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      snap <= '0;
      last_code <= '0;
    end else if (I_CE && I_FAULT_VALID) begin
      // RULE_19 newest event overwrites
      snap <= I_LIVE;
      last_code <= I_FAULT_CODE;
    end
  end

  // RULE_21 category decoded from the same code
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_FAULT_GROUP <= '0;
    end else if (I_CE && I_FAULT_VALID) begin
      O_FAULT_GROUP <= fault_category(I_FAULT_CODE);
    end
  end

  // RULE_20 terminal on any mask overlap, one edge later
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_FAULT_TERM <= '0;
    end else if (I_CE) begin
      for (int m = 0; m < NUM_MASK; m++) begin
        O_FAULT_TERM[m] <= |(mask[m][GRP_W-1:0] & O_FAULT_GROUP);
      end
    end
  end

  // ==========================================================
  // thermistor detection
  // RULE_15 lowest assigned channel is the sensor
  always_comb begin
    therm_en = 1'b0;
    therm_sample = '0;
    for (int c = NUM_AIN - 1; c >= 0; c--) begin
      if (ain_func[c] == AIN_FUNC_THERM) begin
        therm_en = 1'b1;
        therm_sample = I_AIN_LEVEL[c];
      end
    end
  end

  // RULE_14 compare against the programmed level
  assign therm_over = therm_en && above_level(therm_sample, therm_level);

  // RULE_13 reaction per select, registered
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_THERM <= '0;
    end else if (I_CE) begin
      O_THERM <= '0;
      if (therm_over) begin
        case (therm_action_t'(therm_action))
          ACT_WARN_RUN: O_THERM.warn <= 1'b1;
          ACT_WARN_RAMP: begin
            O_THERM.warn <= 1'b1;
            O_THERM.ramp_stop <= 1'b1;
          end
          ACT_WARN_COAST: begin
            O_THERM.warn <= 1'b1;
            O_THERM.coast_stop <= 1'b1;
          end
          default: O_THERM <= '0; // silent reaction
        endcase
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);

  // a fault pulse that the block takes
  sequence s_fault_taken;
    I_CE && I_FAULT_VALID;
  endsequence

  // an enabled cycle with no fault pulse
  sequence s_quiet;
    I_CE && !I_FAULT_VALID;
  endsequence

  a_group_decode: // RULE_01
    assert property (s_fault_taken |=>
      O_FAULT_GROUP == fault_category($past(I_FAULT_CODE)))
    else $error("category vector does not match latched code");

  a_zero_group: // RULE_21
    assert property (s_fault_taken ##0 (I_FAULT_CODE == 8'h00) |=>
      O_FAULT_GROUP == '0)
    else $error("no-fault code left a category bit set");

  a_snap_agree: // RULE_22
    assert property (s_fault_taken |=> (snap == $past(I_LIVE)) &&
      (last_code == $past(I_FAULT_CODE)))
    else $error("snapshot records disagree with the fault");

  a_snap_hold: // RULE_19
    assert property (s_quiet |=> $stable(snap))
    else $error("snapshot changed without a malfunction");

  a_term_mask: // RULE_20
    assert property (I_CE ##1 I_CE |->
      O_FAULT_TERM[0] == |($past(mask[0][GRP_W-1:0]) &
                           $past(O_FAULT_GROUP)))
    else $error("terminal does not follow mask overlap");

  a_therm_silent: // RULE_13
    assert property (I_CE && therm_action == ACT_SILENT |=>
      O_THERM == '0)
    else $error("silent reaction produced a warning");

  a_therm_gate: // RULE_15
    assert property (I_CE && !therm_en |=> !O_THERM.warn)
    else $error("thermistor warned without an assigned channel");

  a_level_range: // RULE_14
    assert property (therm_level <= THERM_LEVEL_MAX)
    else $error("trip level above full scale");

  a_ack_pulse:
    assert property (O_WB_ACK |=> !O_WB_ACK)
    else $error("ack held longer than one cycle");

  // ==========================================================
  // bus and register checks: these watch the slave side only,
  // so a master that breaks the classic handshake fires no
  // bus check here and can still corrupt a register silently
  sequence s_bus_take;
    I_CE && I_WB_CYC && I_WB_STB && !O_WB_ACK;
  endsequence

  sequence s_reg_write;
    I_CE && wr_en;
  endsequence

  // every taken request is answered on the next edge
  a_ack_answer:
    assert property (s_bus_take |=> O_WB_ACK)
    else $error("bus request not answered on the next edge");

  // reaction select lands on the acked edge
  a_action_write: // RULE_13
    assert property (s_reg_write ##0 (I_WB_ADR == OFS_THERM_ACTION &&
      I_WB_SEL[0]) |=> therm_action == $past(I_WB_DAT[1:0]))
    else $error("reaction select write did not land");

  // in-range trip level is stored as written
  a_level_write: // RULE_14
    assert property (s_reg_write ##0 (I_WB_ADR == OFS_THERM_LEVEL &&
      I_WB_SEL[1:0] == 2'h3 &&
      I_WB_DAT[15:0] <= 16'(THERM_LEVEL_MAX)) |=>
      therm_level == $past(I_WB_DAT[9:0]))
    else $error("trip level write did not land");

  // out-of-range trip level is pinned to full scale
  a_level_clamp: // RULE_14
    assert property (s_reg_write ##0 (I_WB_ADR == OFS_THERM_LEVEL &&
      I_WB_SEL[1:0] == 2'h3 &&
      I_WB_DAT[15:0] > 16'(THERM_LEVEL_MAX)) |=>
      therm_level == THERM_LEVEL_MAX)
    else $error("trip level write was not clamped");

  // an enabled cycle with the sensor above its level; the
  // reaction is registered, so outputs show it one edge later
  sequence s_over;
    I_CE && therm_over;
  endsequence

  a_therm_run: // RULE_13
    assert property (s_over ##0 (therm_action == ACT_WARN_RUN) |=>
      O_THERM.warn && !O_THERM.ramp_stop && !O_THERM.coast_stop)
    else $error("keep-running reaction wrong");

  a_therm_ramp: // RULE_13
    assert property (s_over ##0 (therm_action == ACT_WARN_RAMP) |=>
      O_THERM.warn && O_THERM.ramp_stop && !O_THERM.coast_stop)
    else $error("ramp-stop reaction wrong");

  a_therm_coast: // RULE_13
    assert property (s_over ##0 (therm_action == ACT_WARN_COAST) |=>
      O_THERM.warn && !O_THERM.ramp_stop && O_THERM.coast_stop)
    else $error("coast-stop reaction wrong");

  // a low clock enable freezes the latched fault and records
  a_ce_freeze:
    assert property (!I_CE |=> $stable(O_FAULT_GROUP) && $stable(snap) &&
      $stable(last_code))
    else $error("state moved while the clock enable was low");

endmodule

// [rtl/fault_pkg.sv]
// fault group package: register map, reset values, category bits,
// carrier structs and the fault code to category decode.
// assumes a 32-bit classic Wishbone slave with word-aligned registers.
package fault_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_THERM_ACTION = 8'h00;
  localparam logic [7:0] OFS_THERM_LEVEL = 8'h04;
  localparam logic [7:0] OFS_SNAP_FCMD = 8'h08;
  localparam logic [7:0] OFS_SNAP_FOUT = 8'h0c;
  localparam logic [7:0] OFS_SNAP_VOUT = 8'h10;
  localparam logic [7:0] OFS_MASK0 = 8'h14; // four masks, word apart
  localparam logic [7:0] OFS_AIN_FUNC0 = 8'h24; // three channels
  localparam logic [7:0] OFS_STATUS = 8'h30;
  localparam logic [7:0] OFS_STRIDE = 8'h04;

  // ==========================================================
  // widths, counts and reset values
  localparam int NUM_MASK = 4;
  localparam int NUM_AIN = 3;
  localparam int GRP_W = 7;
  localparam logic [1:0] THERM_ACTION_RST = 2'h0;
  localparam logic [9:0] THERM_LEVEL_RST = 10'h1f4; // 50.0 percent
  localparam logic [9:0] THERM_LEVEL_MAX = 10'h3e8; // 100.0 percent
  localparam logic [7:0] AIN_FUNC_THERM = 8'h06;
  localparam logic [15:0] MASK_RST = 16'h0000;
  localparam logic [7:0] AIN_FUNC_RST = 8'h00;

  // ==========================================================
  // category bit positions
  localparam int GRP_CURRENT = 0;
  localparam int GRP_VOLTAGE = 1;
  localparam int overload_group_bit = 2;
  localparam int system_group_bit = 3;
  localparam int feedback_group_bit = 4;
  localparam int external_group_bit = 5;
  localparam int GRP_COMM = 6;

  // thermistor reaction, encoded as software writes it
  typedef enum logic [1:0] {
    ACT_WARN_RUN = 2'h0,
    ACT_WARN_RAMP = 2'h1,
    ACT_WARN_COAST = 2'h2,
    ACT_SILENT = 2'h3
  } therm_action_t;

  // live values captured together on a malfunction
  typedef struct packed {
    logic [15:0] freq_cmd; // 0.01 Hz units
    logic [15:0] out_freq; // 0.01 Hz units
    logic [15:0] out_volt; // 0.1 V units
  } snap_t;

  // thermistor reaction outputs
  typedef struct packed {
    logic warn;
    logic ramp_stop;
    logic coast_stop;
  } therm_out_t;

  // fault code to category vector; unlisted codes give zero
  function automatic logic [GRP_W-1:0] fault_category(
      input logic [7:0] code);
    logic [GRP_W-1:0] g;
    g = '0;
    case (code)
      // RULE_01 undervolt and phase loss
      8'd11, 8'd12, 8'd13, 8'd14, 8'd15: g[GRP_VOLTAGE] = 1'b1;
      // RULE_02 decel backup voltage
      8'd62: g[GRP_VOLTAGE] = 1'b1;
      // RULE_03 overload group codes
      8'd21, 8'd27, 8'd87: g[overload_group_bit] = 1'b1;
      // RULE_04 torque and thermal relay
      8'd128, 8'd129, 8'd134, 8'd135: g[overload_group_bit] = 1'b1;
      // RULE_05 current group codes
      8'd28, 8'd79, 8'd80, 8'd82: g[GRP_CURRENT] = 1'b1;
      // RULE_06 memory and detection errors
      8'd31, 8'd33, 8'd34, 8'd35, 8'd36, 8'd37:
        g[system_group_bit] = 1'b1;
      // RULE_07 tuning, password, version
      8'd40, 8'd52, 8'd127, 8'd142: g[system_group_bit] = 1'b1;
      // RULE_08 safety loop codes
      8'd72, 8'd76, 8'd77, 8'd78: g[system_group_bit] = 1'b1;
      // RULE_09 feedback group codes
      8'd45, 8'd48, 8'd89: g[feedback_group_bit] = 1'b1;
      // RULE_10 external group codes
      8'd49, 8'd50, 8'd51, 8'd61, 8'd63: g[external_group_bit] = 1'b1;
      // RULE_11 timeout and fieldbus faults
      8'd58, 8'd101, 8'd102, 8'd104, 8'd105, 8'd106, 8'd107:
        g[GRP_COMM] = 1'b1;
      // RULE_12 internal link errors
      8'd121, 8'd123, 8'd124, 8'd126: g[GRP_COMM] = 1'b1;
      // RULE_21 unlisted codes clear all
      default: g = '0;
    endcase
    return g;
  endfunction

endpackage

// [tb/fault_group_unit_bench.sv]
// bench for the fault group unit: bus reads, fault events, thermistor
// assumes one 100 MHz clock and the partner model fault_src
`timescale 1ns/100ps
module fault_group_unit_bench;
  import fault_pkg::*;
  logic I_CLK, I_NRST, I_WB_CYC, I_WB_STB, I_WB_WE, O_WB_ACK;
  logic [7:0] I_WB_ADR;
  logic [3:0] I_WB_SEL;
  logic [31:0] I_WB_DAT, O_WB_DAT;
  logic fv;
  logic [7:0] fc;
  snap_t live, v;
  logic [NUM_AIN-1:0][15:0] I_AIN_LEVEL;
  logic [GRP_W-1:0] O_FAULT_GROUP;
  logic [NUM_MASK-1:0] O_FAULT_TERM;
  therm_out_t O_THERM;
  logic [15:0] mask [NUM_MASK];
  logic [31:0] q_rd[$], q_grp[$], q_term[$];
  logic v_d, v_dd;
  logic ce; // clock enable into the block
  integer seed;
  int miscompares, checks_done, m, c, a, k;
  // ==========================================================
  // design and partner
  fault_group_unit i_fault_group_unit (.I_CLK(I_CLK), .I_NRST(I_NRST),
    .I_CE(ce), .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB),
    .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR), .I_WB_SEL(I_WB_SEL),
    .I_WB_DAT(I_WB_DAT), .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK),
    .I_FAULT_VALID(fv), .I_FAULT_CODE(fc), .I_LIVE(live),
    .I_AIN_LEVEL(I_AIN_LEVEL), .O_FAULT_GROUP(O_FAULT_GROUP),
    .O_FAULT_TERM(O_FAULT_TERM), .O_THERM(O_THERM));
  fault_src i_src (.clk(I_CLK), .o_valid(fv), .o_code(fc), .o_live(live));
  // ==========================================================
  // helpers
  task automatic cmp(input logic [31:0] got, exp, input string what);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // expected category vector, written from the code table
  function automatic logic [6:0] grp(input int cd);
    grp = '0;
    case (cd)
      28, 79, 80, 82: grp[0] = 1'b1;
      11, 12, 13, 14, 15, 62: grp[1] = 1'b1;
      21, 27, 87, 128, 129, 134, 135: grp[2] = 1'b1;
      31, 33, 34, 35, 36, 37, 40, 52, 72, 76, 77, 78, 127, 142:
        grp[3] = 1'b1;
      45, 48, 89: grp[4] = 1'b1;
      49, 50, 51, 61, 63: grp[5] = 1'b1;
      58, 101, 102, 104, 105, 106, 107, 121, 123, 124, 126:
        grp[6] = 1'b1;
      default: ;
    endcase
  endfunction
  // classic single cycle; a read pushes its expected word
  task automatic wb(input logic we, input logic [7:0] ad,
      input logic [3:0] s, input logic [31:0] d);
    int n;
    if (!we) q_rd.push_back(d);
    @(posedge I_CLK);
    I_WB_CYC <= 1'b1;
    I_WB_STB <= 1'b1;
    I_WB_WE <= we;
    I_WB_ADR <= ad;
    I_WB_SEL <= s;
    I_WB_DAT <= we ? d : $random(seed);
    n = 0;
    do begin
      @(posedge I_CLK);
      n++;
    end while (O_WB_ACK !== 1'b1 && n < 50);
    I_WB_CYC <= 1'b0;
    I_WB_STB <= 1'b0;
    if (n >= 50) cmp(32'h0, 32'h1, "bus timeout");
  endtask
  // one malfunction event with expected group and terminals queued
  task automatic ev(input int cd, input snap_t sv);
    logic [3:0] t;
    for (int i = 0; i < NUM_MASK; i++) t[i] = |(mask[i][6:0] & grp(cd));
    q_grp.push_back({25'h0, grp(cd)});
    q_term.push_back({28'h0, t});
    @(posedge I_CLK);
    i_src.fire(cd[7:0], sv);
  endtask
  // ==========================================================
  // monitor: results taken off the queues as they appear
  always @(posedge I_CLK) begin
    v_d <= fv;
    v_dd <= v_d;
    if (O_WB_ACK === 1'b1 && !I_WB_WE && q_rd.size() > 0)
      cmp(O_WB_DAT, q_rd.pop_front(), "read data");
    if (v_d && q_grp.size() > 0)
      cmp({25'h0, O_FAULT_GROUP}, q_grp.pop_front(), "group");
    if (v_dd && q_term.size() > 0)
      cmp({28'h0, O_FAULT_TERM}, q_term.pop_front(), "term");
  end
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========================================================
  // clock, watchdog, main sequence
  initial begin
    I_CLK = 1'b0;
    forever #5 I_CLK = ~I_CLK;
  end
  initial begin
    #200000;
    miscompares++;
    end_of_test();
  end
  initial begin
    seed = 32'h7ad3;
    miscompares = 0;
    checks_done = 0;
    {I_NRST, I_WB_CYC, I_WB_STB, I_WB_WE} = 4'h0;
    I_WB_ADR = 8'h00;
    I_WB_SEL = 4'h0;
    I_WB_DAT = 32'h0;
    I_AIN_LEVEL = '1;
    ce = 1'b1;
    i_src.idle();
    repeat (8) @(posedge I_CLK);
    I_NRST <= 1'b1;
    wb(0, OFS_THERM_ACTION, 4'hf, 32'h0);
    wb(0, OFS_THERM_LEVEL, 4'hf, 32'h1f4);
    for (m = 0; m < 3; m++) wb(0, OFS_SNAP_FCMD + 8'(4 * m), 4'hf, 32'h0);
    wb(0, 8'h40, 4'hf, 32'h0);
    $display("test reset values done");
    for (m = 0; m < NUM_MASK; m++) begin
      mask[m] = 16'($random(seed));
      wb(1, OFS_MASK0 + 8'(4 * m), 4'h3, {16'h0, mask[m]});
      wb(0, OFS_MASK0 + 8'(4 * m), 4'hf, {16'h0, mask[m]});
    end
    for (c = 0; c <= 150; c++) begin
      v = {$random(seed), 16'($random(seed))};
      ev(c, v);
    end
    $display("test code sweep done");
    ev(31, {16'hea60, 16'h1234, 16'hffff});
    ev(45, v);
    repeat (3) @(posedge I_CLK);
    for (m = 0; m < 3; m++) begin
      wb(1, OFS_SNAP_FCMD + 8'(4 * m), 4'hf, 32'h5a5a);
      wb(0, OFS_SNAP_FCMD + 8'(4 * m), 4'hf, {16'h0, v[47-16*m -: 16]});
    end
    wb(0, OFS_STATUS, 4'hf, {17'h0, grp(45), 8'd45});
    $display("test snapshots done");
    repeat (3) @(posedge I_CLK);
    cmp({29'h0, O_THERM}, 32'h0, "therm off");
    wb(1, OFS_AIN_FUNC0 + OFS_STRIDE, 4'h1, 32'h6);
    wb(0, OFS_AIN_FUNC0 + OFS_STRIDE, 4'hf, 32'h6);
    wb(1, OFS_THERM_LEVEL, 4'h3, 32'h4b0);
    wb(0, OFS_THERM_LEVEL, 4'hf, 32'h3e8);
    wb(1, OFS_THERM_LEVEL, 4'h3, 32'h1f4);
    for (a = 0; a < 4; a++) begin
      wb(1, OFS_THERM_ACTION, 4'h1, 32'(a));
      for (k = 0; k < 2; k++) begin
        I_AIN_LEVEL[1] <= 16'h7fff + 16'(k);
        repeat (3) @(posedge I_CLK);
        cmp({29'h0, O_THERM}, (k == 0 || a == 3) ? 32'h0 :
            {29'h1, a == 1, a == 2}, "therm");
      end
    end
    $display("test thermistor done");
    // clock enable low: a fault pulse must not be taken
    ce <= 1'b0;
    i_src.fire(8'd11, ~v);
    repeat (2) @(posedge I_CLK);
    ce <= 1'b1;
    cmp({25'h0, O_FAULT_GROUP}, {25'h0, grp(45)}, "ce freeze");
    wb(0, OFS_SNAP_FCMD, 4'hf, {16'h0, v[47:32]});
    $display("test clock enable done");
    // reset in mid-run brings back the reset values
    I_NRST <= 1'b0;
    repeat (2) @(posedge I_CLK);
    I_NRST <= 1'b1;
    wb(0, OFS_THERM_ACTION, 4'hf, 32'h0);
    wb(0, OFS_THERM_LEVEL, 4'hf, 32'h1f4);
    cmp({29'h0, O_THERM}, 32'h0, "therm after reset");
    $display("test mid-run reset done");
    end_of_test();
  end
endmodule

// [tb/fault_src.sv]
// partner model: drive firmware raising malfunction events
// assumes fire() is called just after a rising edge of clk
`timescale 1ns/100ps
module fault_src (
  input wire logic clk,
  output logic o_valid,
  output logic [7:0] o_code,
  output fault_pkg::snap_t o_live
);
  import fault_pkg::*;
  // idle event lines, called once by the bench at time zero so
  // that every drive of these lines comes from one process
  task automatic idle;
    o_valid = 1'b0;
    o_code = 8'h00;
    o_live = '0;
  endtask
  // one-cycle event; code and values scrambled outside it so that
  // a late sample in the block cannot pass by luck
  task automatic fire(input logic [7:0] c, input snap_t v);
    o_valid <= 1'b1;
    o_code <= c;
    o_live <= v;
    @(posedge clk);
    o_valid <= 1'b0;
    o_code <= ~c;
    o_live <= ~v;
  endtask
endmodule
